// >>> hw/cct_timer.sv
// 8/16-bit capture/compare timer with prescaler, event counting and capture
`timescale 1ns/100ps
module cct_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic [2:0]  reg_sel_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wide_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        external_edge_input_i,
  output logic             compare_match_irq_o,
  output logic             capcmp_match_irq_o,
  output logic             rto_trigger_o
);
  import cct_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] width_mask(input logic wide);
    width_mask = wide ? CCT_MASK_16 : CCT_MASK_8;
  endfunction

  // byte write touches only the low lane, halfword both
  function automatic logic [15:0] merge_write(input logic [15:0] old, input logic wide,
                                              input logic [15:0] wd);
    merge_write = wide ? wd : {old[15:8], wd[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] count_reg;
  logic [15:0] compare_value_reg;
  logic [15:0] capcmp_value_reg;
  logic [3:0]  timer_control_reg;
  logic [3:0]  prescaler_select_reg;
  logic [2:0]  capture_compare_control_reg;
  logic [1:0]  sampling_clock_select_reg;
  logic        overflow_flag_reg;
  cct_run_t    run_reg;
  cct_run_t    run_next;
  logic [9:0]  div_reg;
  logic        ext_smp_reg;
  logic        ext_prev_reg;
  logic        edge_reg;
  logic        cap_clear_reg;
  logic        cmp_irq_reg;
  logic        capcmp_irq_reg;

  logic        wide;
  logic [15:0] mask;
  logic        ce_bit;
  logic        wr_tmc;
  logic        wr_cmp;
  logic        wr_capcmp;
  logic        cap_mode;
  logic        prs_tick;
  logic        smp_tick;
  logic        count_tick;
  logic        counting;
  logic [15:0] count_inc;
  logic        wrap;
  logic        hit_cmp;
  logic        hit_capcmp;
  logic        clear_cmp;
  logic        clear_capcmp;
  logic [9:0]  prs_mask;
  logic [9:0]  smp_mask;

  assign wide      = timer_control_reg[CCT_TMC_WIDE_BIT];
  assign mask      = width_mask(wide);
  assign ce_bit    = timer_control_reg[CCT_TMC_CE_BIT];
  assign wr_tmc    = reg_wr_i && (reg_sel_i == CCT_SEL_TMC);
  assign wr_cmp    = reg_wr_i && (reg_sel_i == CCT_SEL_CMP);
  assign wr_capcmp = reg_wr_i && (reg_sel_i == CCT_SEL_CAPCMP);
  assign cap_mode  = capture_compare_control_reg[CCT_CRC_CM_BIT];

  // ---------------------------------------------------------------
  // prescaler and input sampling
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 10'h000;
    end else if (clk_en_i) begin
      div_reg <= div_reg + 10'h001;
    end
  end

  // codes 1..9 give fxx/8 .. fxx/2048 on a shared free-running divider
  always_comb begin
    prs_mask = (CCT_DIV_BASE << (prescaler_select_reg - 4'h1)) - 10'h001;
    smp_mask = (CCT_SMP_BASE << (sampling_clock_select_reg - 2'h1)) - 10'h001;
  end

  assign prs_tick = (prescaler_select_reg != 4'h0) && (prescaler_select_reg <= CCT_PRM_MAX)
                    && ((div_reg & prs_mask) == prs_mask);
  // fclk sampling by default; divided sampling limits the shortest pulse
  assign smp_tick = (sampling_clock_select_reg == 2'h0)
                    || ((div_reg & smp_mask) == smp_mask);

  // pin is synchronous; a rising edge seen on two samples is the valid edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_smp_reg  <= 1'b0;
      ext_prev_reg <= 1'b0;
      edge_reg     <= 1'b0;
    end else if (clk_en_i) begin
      edge_reg <= 1'b0;
      if (smp_tick) begin
        ext_smp_reg  <= external_edge_input_i;
        ext_prev_reg <= ext_smp_reg;
        edge_reg     <= ext_smp_reg && !ext_prev_reg;
      end
    end
  end

  assign count_tick = (prescaler_select_reg == CCT_PRM_EXT) ? edge_reg : prs_tick;

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  always_comb begin
    run_next = run_reg;
    case (run_reg)
      CCT_STOPPED: begin
        if (ce_bit) begin
          run_next = CCT_ARMED;
        end
      end
      CCT_ARMED: begin
        if (!ce_bit) begin
          run_next = CCT_STOPPED;
        end else if (count_tick) begin
          run_next = CCT_RUNNING;
        end
      end
      CCT_RUNNING: begin
        if (!ce_bit) begin
          run_next = CCT_STOPPED;
        end
      end
      default: run_next = CCT_STOPPED;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_reg <= CCT_STOPPED;
    end else if (clk_en_i) begin
      run_reg <= run_next;
    end
  end

  assign counting = ce_bit && (run_reg == CCT_RUNNING) && count_tick;

  // ---------------------------------------------------------------
  // counter, match and overflow
  // ---------------------------------------------------------------
  assign count_inc = (count_reg + 16'h0001) & mask;
  assign wrap      = (count_reg & mask) == mask;
  // match seen only as the count steps, never during a write to that register
  assign hit_cmp    = counting && !wr_cmp
                      && (count_inc == (compare_value_reg & mask));
  assign hit_capcmp = counting && !cap_mode && !wr_capcmp
                      && (count_inc == (capcmp_value_reg & mask));
  assign clear_cmp    = capture_compare_control_reg[CCT_CRC_CLR10_BIT]
                        && ((count_reg & mask) == (compare_value_reg & mask));
  assign clear_capcmp = capture_compare_control_reg[CCT_CRC_CLR11_BIT] && !cap_mode
                        && ((count_reg & mask) == (capcmp_value_reg & mask));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= CCT_COUNT_RST;
    end else if (clk_en_i) begin
      if (!ce_bit) begin
        count_reg <= CCT_COUNT_RST;
      end else if (run_reg == CCT_ARMED && count_tick) begin
        count_reg <= CCT_COUNT_RST;
      end else if (counting) begin
        if (clear_cmp || clear_capcmp || cap_clear_reg) begin
          count_reg <= CCT_COUNT_RST;
        end else begin
          count_reg <= count_inc;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_flag_reg <= 1'b0;
    end else if (clk_en_i) begin
      // a wrap in the clearing cycle wins over the software clear
      if (counting && wrap && !(clear_cmp || clear_capcmp || cap_clear_reg)) begin
        overflow_flag_reg <= 1'b1;
      end else if (wr_tmc && !reg_wdata_i[CCT_TMC_OVF_BIT]) begin
        overflow_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_irq_reg    <= 1'b0;
      capcmp_irq_reg <= 1'b0;
    end else if (clk_en_i) begin
      cmp_irq_reg    <= hit_cmp;
      capcmp_irq_reg <= hit_capcmp;
    end else begin
      cmp_irq_reg    <= 1'b0;
      capcmp_irq_reg <= 1'b0;
    end
  end

  assign compare_match_irq_o = cmp_irq_reg;
  assign capcmp_match_irq_o  = capcmp_irq_reg;
  assign rto_trigger_o       = cmp_irq_reg;

  // ---------------------------------------------------------------
  // compare and capture/compare storage, no reset on purpose
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (clk_en_i && wr_cmp) begin
      compare_value_reg <= merge_write(compare_value_reg, reg_wide_i, reg_wdata_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (clk_en_i) begin
      if (cap_mode && ce_bit && edge_reg) begin
        capcmp_value_reg <= count_reg & mask;
      end else if (wr_capcmp) begin
        capcmp_value_reg <= merge_write(capcmp_value_reg, reg_wide_i, reg_wdata_i);
      end
    end
  end

  // capture with clear: counter restarts on the next count clock
  // a new capture wins over the count clock that consumes the old request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_clear_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (!ce_bit) begin
        cap_clear_reg <= 1'b0;
      end else if (cap_mode && edge_reg
                   && capture_compare_control_reg[CCT_CRC_CLR11_BIT]) begin
        cap_clear_reg <= 1'b1;
      end else if (counting) begin
        cap_clear_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers and read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_control_reg           <= CCT_TMC_RST;
      prescaler_select_reg        <= CCT_PRM_RST;
      capture_compare_control_reg <= CCT_CRC_RST;
      sampling_clock_select_reg   <= CCT_SCS_RST;
    end else if (clk_en_i && reg_wr_i) begin
      case (reg_sel_i)
        CCT_SEL_TMC: timer_control_reg           <= reg_wdata_i[3:0];
        CCT_SEL_PRM: prescaler_select_reg        <= reg_wdata_i[3:0];
        CCT_SEL_CRC: capture_compare_control_reg <= reg_wdata_i[2:0];
        CCT_SEL_SCS: sampling_clock_select_reg   <= reg_wdata_i[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (clk_en_i && reg_rd_i) begin
      case (reg_sel_i)
        CCT_SEL_COUNT:  reg_rdata_o <= count_reg & width_mask(reg_wide_i);
        CCT_SEL_CMP:    reg_rdata_o <= compare_value_reg & width_mask(reg_wide_i);
        CCT_SEL_CAPCMP: reg_rdata_o <= capcmp_value_reg & width_mask(reg_wide_i);
        CCT_SEL_TMC:    reg_rdata_o <= {12'h000, timer_control_reg[3],
                                        overflow_flag_reg, 1'b0, timer_control_reg[0]};
        CCT_SEL_PRM:    reg_rdata_o <= {12'h000, prescaler_select_reg};
        CCT_SEL_CRC:    reg_rdata_o <= {13'h0000, capture_compare_control_reg};
        CCT_SEL_SCS:    reg_rdata_o <= {14'h0000, sampling_clock_select_reg};
        default:        reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_armed_tick;
    clk_en_i && ce_bit && (run_reg == CCT_ARMED) && count_tick;
  endsequence

  sequence s_first_steps;
    (count_reg == 16'h0000) ##1 (run_reg == CCT_RUNNING);
  endsequence

  chk_stop_zero: assert property (clk_en_i && !ce_bit |=> count_reg == 16'h0000)
    else $error("counter not zero while stopped");

  chk_start_clear: assert property (s_armed_tick |=> s_first_steps)
    else $error("first count clock did not clear and start");

  chk_match_cause: assert property (compare_match_irq_o
      |-> (count_reg & mask) == (compare_value_reg & mask) && $past(ce_bit))
    else $error("match request without equal count");

  chk_match_pulse: assert property (compare_match_irq_o |=> !compare_match_irq_o)
    else $error("match request longer than one clock");

  chk_rto_follows: assert property (rto_trigger_o == compare_match_irq_o)
    else $error("output trigger differs from match request");

  chk_ovf_wrap: assert property (clk_en_i && counting && wrap
      && !(clear_cmp || clear_capcmp || cap_clear_reg) |=> overflow_flag_reg)
    else $error("wrap did not set overflow");

  chk_capture_value: assert property (clk_en_i && cap_mode && ce_bit && edge_reg
      |=> capcmp_value_reg == ($past(count_reg) & $past(mask)))
    else $error("capture did not latch count");

  chk_narrow_width: assert property (clk_en_i && counting && !wide
      |=> count_reg[15:8] == 8'h00)
    else $error("8-bit count exceeded its width");

  chk_hold_idle: assert property (clk_en_i && ce_bit && !count_tick
      |=> $stable(count_reg))
    else $error("count moved without a count clock");

endmodule // cct_timer

// >>> shared/cct_pkg.sv
// constants, register map and types of the capture/compare timer
// Function
// - counter increments on each count clock picked by prescaler select low nibble
// - control register starts/stops counting and picks 8-bit or 16-bit width
// - reset clears the counter to zero and leaves counting stopped
// - counter readable by byte or halfword only; no single-bit accesses
// - counter equal to compare value raises the compare-match interrupt request
// - compare-match also drives the real-time output port trigger
// - with clear-on-match enabled a compare match clears the count
// - compare value is 8 or 16 bits wide following mode; compare matches width
// - compare and capture/compare values are not initialised by reset
// - compare value readable and writable by byte or halfword accesses
// - control bit makes second register a compare or a capture register
// - capture/compare value is 8 bits wide in 8-bit mode, 16 in 16-bit
// - interval mode gives periodic interrupts, 8/fxx to 2048/fxx per count
// - pulse-width mode measures external input pulses with counter resolution
// - minimum pulse is larger of count resolution and sampling clock limit
// - event-counter mode counts pulses on the external input
// - enabling from stopped clears counter on first count clock; writing enable again while running keeps count
// - disabling forces counter to zero and stops capture and match generation
// - wrap from all ones sets overflow flag, counting goes on; software clears it
// - capture mode latches counter on valid external edge and holds it
package cct_pkg;

  // ---------------------------------------------------------------
  // register selects
  // ---------------------------------------------------------------
  localparam logic [2:0] CCT_SEL_COUNT  = 3'h0;
  localparam logic [2:0] CCT_SEL_CMP    = 3'h1;
  localparam logic [2:0] CCT_SEL_CAPCMP = 3'h2;
  localparam logic [2:0] CCT_SEL_TMC    = 3'h3;
  localparam logic [2:0] CCT_SEL_PRM    = 3'h4;
  localparam logic [2:0] CCT_SEL_CRC    = 3'h5;
  localparam logic [2:0] CCT_SEL_SCS    = 3'h6;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CCT_TMC_WIDE_BIT  = 0;
  localparam int CCT_TMC_OVF_BIT   = 2;
  localparam int CCT_TMC_CE_BIT    = 3;
  localparam int CCT_CRC_CLR10_BIT = 0;
  localparam int CCT_CRC_CLR11_BIT = 1;
  localparam int CCT_CRC_CM_BIT    = 2;

  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [15:0] CCT_COUNT_RST = 16'h0000;
  localparam logic [3:0]  CCT_TMC_RST   = 4'h0;
  localparam logic [3:0]  CCT_PRM_RST   = 4'h1;
  localparam logic [2:0]  CCT_CRC_RST   = 3'h0;
  localparam logic [1:0]  CCT_SCS_RST   = 2'h0;
  localparam logic [3:0]  CCT_PRM_EXT   = 4'hB;
  localparam logic [3:0]  CCT_PRM_MAX   = 4'h9;
  localparam logic [15:0] CCT_MASK_8    = 16'h00FF;
  localparam logic [15:0] CCT_MASK_16   = 16'hFFFF;
  // fxx runs at twice the system clock, so fxx/8 is one count per 4 clocks
  localparam int          CCT_FXX_PER_CLK = 2;
  localparam int          CCT_FXX_DIV_MIN = 8;
  localparam logic [9:0]  CCT_DIV_BASE  = 10'(CCT_FXX_DIV_MIN / CCT_FXX_PER_CLK);
  localparam logic [9:0]  CCT_SMP_BASE  = 10'(64 / CCT_FXX_PER_CLK);

  typedef enum logic [1:0] {
    CCT_STOPPED = 2'b00,
    CCT_ARMED   = 2'b01,
    CCT_RUNNING = 2'b10
  } cct_run_t;

endpackage

// >>> tb/cct_pin_model.sv
// external edge source model driving the timer's capture/event pin
`timescale 1ns/100ps
module cct_pin_model (
  input  wire logic clk_i,
  output logic      pin_o
);
  initial pin_o = 1'b0;

  // -------------------------------------------------
  // pulse train
  // -------------------------------------------------
  // each level held at least 4 clocks so every edge survives fclk sampling
  task automatic pulses(input int n, input int w);
    int k;
    int ww;
    ww = (w < 4) ? 4 : w;
    for (k = 0; k < n; k++) begin
      @(negedge clk_i);
      pin_o = 1'b1;
      repeat (ww) @(negedge clk_i);
      pin_o = 1'b0;
      repeat (ww) @(negedge clk_i);
    end
  endtask
endmodule // cct_pin_model

// >>> tb/tb.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import cct_pkg::*;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [2:0]  sel     = 3'h0;
  logic        wr_s    = 1'b0;
  logic        rd_s    = 1'b0;
  logic        wide    = 1'b0;
  logic        en      = 1'b1;
  logic [15:0] wdata   = 16'h0000;
  logic [15:0] rdata;
  logic        pin;
  logic        irq;
  logic        irq2;
  logic        rto;
  logic [15:0] v, c1, c2, r;
  int          errors = 0, cmp_count = 0, cyc = 0, seed = 86, i, n, bad;
  logic [2:0]  rs [6] = '{CCT_SEL_COUNT, CCT_SEL_TMC, CCT_SEL_PRM, CCT_SEL_CRC,
                          CCT_SEL_SCS, 3'h7};
  logic [15:0] re [6] = '{CCT_COUNT_RST, 16'(CCT_TMC_RST), 16'(CCT_PRM_RST),
                          16'(CCT_CRC_RST), 16'(CCT_SCS_RST), 16'h0000};

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  cct_timer dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(en), .reg_sel_i(sel),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_wide_i(wide), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .external_edge_input_i(pin), .compare_match_irq_o(irq),
    .capcmp_match_irq_o(irq2), .rto_trigger_o(rto));
  cct_pin_model pin_u (.clk_i(clk_i), .pin_o(pin));

  // -------------------------------------------------
  // bus and check tasks
  // -------------------------------------------------
  task automatic wr(input logic [2:0] s, input logic [15:0] d, input logic w);
    @(negedge clk_i);
    sel = s; wdata = d; wide = w; wr_s = 1'b1;
    @(negedge clk_i);
    wr_s = 1'b0;
  endtask

  task automatic rd(input logic [2:0] s, input logic w, output logic [15:0] d);
    @(negedge clk_i);
    sel = s; wide = w; rd_s = 1'b1;
    @(negedge clk_i);
    rd_s = 1'b0;
    d = rdata;
  endtask

  task automatic wait_irq(output int t);
    int k;
    for (k = 0; k < 20000; k++) begin
      @(negedge clk_i);
      if (irq === 1'b1) break;
    end
    t = cyc;
    `CHK(irq, 1'b1)
    `CHK(rto, 1'b1)
    `CHK(irq2, 1'b1)
    @(negedge clk_i);
    `CHK(irq, 1'b0)
  endtask

  // cycles between two matches: count clock period times counts per period
  function automatic int exp_period(input logic [3:0] p, input logic [15:0] c,
                                    input logic w, input logic clr);
    logic [15:0] m;
    m = w ? CCT_MASK_16 : CCT_MASK_8;
    exp_period = (clr ? (c & m) + 1 : m + 1) * (4 << (p - 1));
  endfunction

  // period between matches; clr picks clear-on-match or free wrap
  task automatic interval(input logic [3:0] p, input logic [15:0] c,
                          input logic w, input logic clr);
    int t0, t1;
    logic [15:0] x;
    wr(CCT_SEL_TMC, 16'h0000, 1'b0);
    wr(CCT_SEL_PRM, {12'h000, p}, 1'b0);
    wr(CCT_SEL_CMP, c, 1'b1);
    wr(CCT_SEL_CAPCMP, c, 1'b1);
    wr(CCT_SEL_CRC, {15'h0000, clr}, 1'b0);
    wr(CCT_SEL_TMC, {12'h000, 3'b100, w}, 1'b0);
    wait_irq(t0);
    wait_irq(t1);
    `CHK(t1 - t0, exp_period(p, c, w, clr))
    rd(CCT_SEL_TMC, 1'b0, x);
    `CHK(x[CCT_TMC_OVF_BIT], ~clr)
    wr(CCT_SEL_TMC, {12'h000, 3'b100, w}, 1'b0);
    rd(CCT_SEL_TMC, 1'b0, x);
    `CHK(x[CCT_TMC_OVF_BIT], 1'b0)
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // -------------------------------------------------
  // watchdog
  // -------------------------------------------------
  // tests need under 30k cycles; a hang still ends below 100k
  initial begin
    #(40 * 90000);
    errors++;
    complete_run();
  end

  // -------------------------------------------------
  // main sequence
  // -------------------------------------------------
  initial begin
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (i = 0; i < 6; i++) begin
      rd(rs[i], 1'b1, v);
      `CHK(v, re[i])
    end
    $display("test reset_values done");
    for (i = 1; i < 3; i++) begin
      r = 16'($random(seed));
      v = 16'($random(seed));
      wr(3'(i), r, 1'b1);
      wr(3'(i), v, 1'b0);
      rd(3'(i), 1'b1, c1);
      `CHK(c1, {r[15:8], v[7:0]})
      rd(3'(i), 1'b0, c1);
      `CHK(c1, {8'h00, v[7:0]})
    end
    wr(CCT_SEL_COUNT, r, 1'b1);
    rd(CCT_SEL_COUNT, 1'b1, c1);
    `CHK(c1, 16'h0000)
    $display("test byte_access done");
    r = 16'($random(seed));
    interval(4'h1, {r[15:8], 8'h05}, 1'b0, 1'b1);
    interval(4'h1, {r[7:0], 8'h07}, 1'b0, 1'b0);
    for (i = 1; i < 10; i++) begin
      interval(4'(i), 16'(1 + ($random(seed) & 3)), 1'b1, 1'b1);
    end
    $display("test interval done");
    // slowest count clock, so reads never hit an unsafe pairing
    wr(CCT_SEL_CRC, 16'h0000, 1'b0);
    rd(CCT_SEL_COUNT, 1'b1, c1);
    wr(CCT_SEL_TMC, 16'h0009, 1'b0);
    rd(CCT_SEL_COUNT, 1'b1, c2);
    `CHK(c2 - c1 < 2, 1'b1)
    wr(CCT_SEL_TMC, 16'h0000, 1'b0);
    rd(CCT_SEL_COUNT, 1'b1, c1);
    `CHK(c1, 16'h0000)
    bad = 0;
    repeat (3000) begin
      @(negedge clk_i);
      if (irq !== 1'b0) bad++;
    end
    `CHK(bad, 0)
    $display("test stop_restart done");
    wr(CCT_SEL_PRM, {12'h000, CCT_PRM_EXT}, 1'b0);
    wr(CCT_SEL_SCS, 16'h0000, 1'b0);
    wr(CCT_SEL_TMC, 16'h0009, 1'b0);
    n = 3 + ($random(seed) & 7);
    pin_u.pulses(n, 4 + ($random(seed) & 3));
    repeat (4) @(negedge clk_i);
    rd(CCT_SEL_COUNT, 1'b1, c1);
    `CHK(c1, 16'(n - 1))
    // divided sampling: levels held long enough to be seen on 32-clock samples
    wr(CCT_SEL_TMC, 16'h0000, 1'b0);
    wr(CCT_SEL_SCS, 16'h0001, 1'b0);
    wr(CCT_SEL_TMC, 16'h0009, 1'b0);
    pin_u.pulses(3, 128);
    rd(CCT_SEL_COUNT, 1'b1, c1);
    `CHK(c1, 16'h0002)
    wr(CCT_SEL_SCS, 16'h0000, 1'b0);
    $display("test event_count done");
    wr(CCT_SEL_TMC, 16'h0000, 1'b0);
    wr(CCT_SEL_PRM, 16'h0001, 1'b0);
    wr(CCT_SEL_CRC, 16'h0004, 1'b0);
    wr(CCT_SEL_TMC, 16'h0009, 1'b0);
    repeat (1100) @(negedge clk_i);
    rd(CCT_SEL_COUNT, 1'b1, c1);
    pin_u.pulses(1, 4);
    rd(CCT_SEL_CAPCMP, 1'b1, v);
    rd(CCT_SEL_COUNT, 1'b1, c2);
    `CHK((v >= c1) && (v <= c2), 1'b1)
    repeat (2100) @(negedge clk_i);
    rd(CCT_SEL_CAPCMP, 1'b1, r);
    `CHK(r, v)
    // clock enable low freezes the count and the prescaler
    rd(CCT_SEL_COUNT, 1'b1, c1);
    en = 1'b0;
    repeat (50) @(negedge clk_i);
    en = 1'b1;
    rd(CCT_SEL_COUNT, 1'b1, c2);
    `CHK(c2 - c1 < 3, 1'b1)
    wr(CCT_SEL_TMC, 16'h0000, 1'b0);
    pin_u.pulses(1, 4);
    rd(CCT_SEL_CAPCMP, 1'b1, r);
    `CHK(r, v)
    // capture with clear: count restarts soon after the edge
    wr(CCT_SEL_CRC, 16'h0006, 1'b0);
    wr(CCT_SEL_TMC, 16'h0009, 1'b0);
    repeat (400) @(negedge clk_i);
    pin_u.pulses(1, 4);
    rd(CCT_SEL_COUNT, 1'b1, c2);
    rd(CCT_SEL_CAPCMP, 1'b1, v);
    `CHK((c2 < 16'h0004) && (v > 16'h0040), 1'b1)
    $display("test capture done");
    complete_run();
  end
endmodule // tb
